/* File: flag_skip_map.vh */
// constants for the flag skip instruction unit
`ifndef FLAG_SKIP_MAP_VH
`define FLAG_SKIP_MAP_VH

// instruction words, 10 bits
`define OPC_WIDTH            10
`define OPC_SKIP_POWERDOWN   10'h003
`define OPC_SKIP_TIMER_ONE   10'h280
`define OPC_SKIP_TIMER_TWO   10'h281

// enable bits inside interrupt_control_reg_one
`define IRQ_CTRL_WIDTH       4
`define IRQ_CTRL_RESET       4'h0
`define TIMER_ONE_EN_BIT     2
`define TIMER_TWO_EN_BIT     3

// register byte addresses
`define ADDR_WIDTH           4
`define ADDR_IRQ_CTRL        4'h0
`define ADDR_FLAG_STATUS     4'h4

// flag status fields
`define STAT_POWERDOWN_BIT   0
`define STAT_TIMER_ONE_BIT   1
`define STAT_TIMER_TWO_BIT   2
`define STAT_SKIP_BIT        3
`define NUM_TIMER_FLAGS      2

`endif

/* File: request_flag_cell.v */
// one sticky request flag with set-over-clear priority
`timescale 1ns/1ps
module request_flag_cell (
    // clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // set and clear
    input  wire set_i,
    input  wire clear_i,
    // flag state
    output reg  flag_o
);
    always @(posedge clk_i) begin
        if (rst_i) begin
            flag_o <= 1'b0;
        // set wins so no event is lost
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clear_i) begin
            flag_o <= 1'b0;
        end
    end
endmodule // request_flag_cell

/* File: flag_skip_instruction_unit.v */
// decode and execute of the three flag skip instructions
//
// Behaviour
// - the power-down skip word is one word and one cycle and skips the next instruction when powerdown_flag is 1.
// - the timer 1 skip word, with timer_one_irq_enable 0, skips the next instruction when timer_one_request_flag is 1.
// - a timer 1 skip clears timer_one_request_flag, and a flag of 0 lets the next instruction run.
// - with timer_one_irq_enable 1 the timer 1 skip word is a no-operation that leaves the flag alone.
// - timer_one_irq_enable is bit 2 of interrupt_control_reg_one.
// - the timer 2 skip word, with timer_two_irq_enable 0, skips the next instruction when timer_two_request_flag is 1.
// - a timer 2 skip clears timer_two_request_flag, and a flag of 0 lets the next instruction run.
// - with timer_two_irq_enable 1 the timer 2 skip word is a no-operation that leaves the flag alone.
// - timer_two_irq_enable is bit 3 of interrupt_control_reg_one.
`timescale 1ns/1ps
`include "flag_skip_map.vh"
module flag_skip_instruction_unit (
    // clock and reset
    input  wire                   clk_i,
    input  wire                   rst_i,
    // instruction stream from the core
    input  wire                   instr_valid_i,
    input  wire [`OPC_WIDTH-1:0]  instr_i,
    // flag sources on the core clock
    input  wire                   powerdown_flag_i,
    input  wire                   timer_one_event_i,
    input  wire                   timer_two_event_i,
    // execute results
    output reg                    skip_o,
    output reg                    timer_one_request_flag_o,
    output reg                    timer_two_request_flag_o,
    output reg  [`IRQ_CTRL_WIDTH-1:0] interrupt_control_o,
    // wishbone slave
    input  wire                   cyc_i,
    input  wire                   stb_i,
    input  wire                   we_i,
    input  wire [`ADDR_WIDTH-1:0] adr_i,
    input  wire [3:0]             sel_i,
    input  wire [31:0]            dat_i,
    output reg  [31:0]            dat_o,
    output reg                    ack_o
);
    // skip tracker states
    localparam SKIP_IDLE = 1'b0;
    localparam SKIP_PEND = 1'b1;
    // bus slave states
    localparam BUS_IDLE  = 1'b0;
    localparam BUS_ACK   = 1'b1;

    reg  [`IRQ_CTRL_WIDTH-1:0] interrupt_control_reg_one_r;
    reg                        skip_state_r;
    reg                        skip_state_nxt;
    reg                        bus_state_r;
    reg                        bus_state_nxt;
    reg                        dec_pd;
    reg  [`NUM_TIMER_FLAGS-1:0] dec_timer;
    wire                       skip_pending;
    wire                       skip_hit;
    wire                       wb_done;
    wire [`NUM_TIMER_FLAGS-1:0] flag_q;
    wire [`NUM_TIMER_FLAGS-1:0] flag_set;
    wire [`NUM_TIMER_FLAGS-1:0] flag_clr;
    wire [`NUM_TIMER_FLAGS-1:0] enable_bit;
    wire [`NUM_TIMER_FLAGS-1:0] is_opc;
    wire [`NUM_TIMER_FLAGS-1:0] sw_clr;
    wire                       exec;
    wire                       wb_req;
    wire                       wb_wr;
    wire                       hit_pd;
    wire [`NUM_TIMER_FLAGS-1:0] hit_timer;
    reg  [31:0]                rd_nxt;

    // a skipped word is dropped, never executed
    assign skip_pending = (skip_state_r == SKIP_PEND);
    assign exec         = instr_valid_i & ~skip_pending;
    // taken in idle, completed while ack stands
    assign wb_req       = cyc_i & stb_i & (bus_state_r == BUS_IDLE);
    assign wb_done      = cyc_i & stb_i & (bus_state_r == BUS_ACK);
    // writes land on the edge the master sees ack
    assign wb_wr        = wb_done & we_i & sel_i[0];

    assign enable_bit[0] = interrupt_control_reg_one_r[`TIMER_ONE_EN_BIT];
    assign enable_bit[1] = interrupt_control_reg_one_r[`TIMER_TWO_EN_BIT];
    assign is_opc        = dec_timer;

    // opcode decode, every other word is ignored
    always @* begin
        dec_pd    = 1'b0;
        dec_timer = {`NUM_TIMER_FLAGS{1'b0}};
        case (instr_i)
            `OPC_SKIP_POWERDOWN: begin
                dec_pd = 1'b1;
            end
            `OPC_SKIP_TIMER_ONE: begin
                dec_timer[0] = 1'b1;
            end
            `OPC_SKIP_TIMER_TWO: begin
                dec_timer[1] = 1'b1;
            end
            default: begin
                dec_pd    = 1'b0;
                dec_timer = {`NUM_TIMER_FLAGS{1'b0}};
            end
        endcase
    end

    assign flag_set[0]   = timer_one_event_i;
    assign flag_set[1]   = timer_two_event_i;
    assign sw_clr[0]     = wb_wr & (adr_i == `ADDR_FLAG_STATUS) & dat_i[`STAT_TIMER_ONE_BIT];
    assign sw_clr[1]     = wb_wr & (adr_i == `ADDR_FLAG_STATUS) & dat_i[`STAT_TIMER_TWO_BIT];

    assign hit_pd   = exec & dec_pd & powerdown_flag_i;
    assign skip_hit = hit_pd | (|hit_timer);

    genvar g;
    generate
        for (g = 0; g < `NUM_TIMER_FLAGS; g = g + 1) begin : g_timer
            // skip on enabled-off and flag set
            assign hit_timer[g] = exec & is_opc[g] & ~enable_bit[g] & flag_q[g];
            assign flag_clr[g]  = hit_timer[g] | sw_clr[g];
            request_flag_cell u_flag (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .set_i   (flag_set[g]),
                .clear_i (flag_clr[g]),
                .flag_o  (flag_q[g])
            );
        end
    endgenerate

    // skip covers exactly the next valid word
    always @* begin
        skip_state_nxt = skip_state_r;
        case (skip_state_r)
            SKIP_IDLE: begin
                if (skip_hit) begin
                    skip_state_nxt = SKIP_PEND;
                end
            end
            SKIP_PEND: begin
                // the dropped word consumes the skip
                if (instr_valid_i) begin
                    skip_state_nxt = SKIP_IDLE;
                end
            end
            default: begin
                skip_state_nxt = SKIP_IDLE;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            skip_state_r <= SKIP_IDLE;
        end else begin
            skip_state_r <= skip_state_nxt;
        end
    end

    // register read mux
    always @* begin
        rd_nxt = 32'h0000_0000;
        case (adr_i)
            `ADDR_IRQ_CTRL: begin
                rd_nxt[`IRQ_CTRL_WIDTH-1:0] = interrupt_control_reg_one_r;
            end
            `ADDR_FLAG_STATUS: begin
                rd_nxt[`STAT_POWERDOWN_BIT] = powerdown_flag_i;
                rd_nxt[`STAT_TIMER_ONE_BIT] = flag_q[0];
                rd_nxt[`STAT_TIMER_TWO_BIT] = flag_q[1];
                rd_nxt[`STAT_SKIP_BIT]      = skip_pending;
            end
            default: begin
                rd_nxt = 32'h0000_0000;
            end
        endcase
    end

    // bus handshake, ack stands one cycle then drops
    always @* begin
        bus_state_nxt = bus_state_r;
        case (bus_state_r)
            BUS_IDLE: begin
                if (wb_req) begin
                    bus_state_nxt = BUS_ACK;
                end
            end
            BUS_ACK: begin
                // master must release before the next request
                bus_state_nxt = BUS_IDLE;
            end
            default: begin
                bus_state_nxt = BUS_IDLE;
            end
        endcase
    end

    // wishbone slave, unmapped reads zero, writes ignored
    always @(posedge clk_i) begin
        if (rst_i) begin
            bus_state_r                 <= BUS_IDLE;
            interrupt_control_reg_one_r <= `IRQ_CTRL_RESET;
            ack_o                       <= 1'b0;
            dat_o                       <= 32'h0000_0000;
        end else begin
            bus_state_r <= bus_state_nxt;
            ack_o       <= (bus_state_nxt == BUS_ACK);
            if (wb_req) begin
                dat_o <= rd_nxt;
            end
            if (wb_wr && adr_i == `ADDR_IRQ_CTRL) begin
                interrupt_control_reg_one_r <= dat_i[`IRQ_CTRL_WIDTH-1:0];
            end
        end
    end

    // registered copies for the outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            skip_o                   <= 1'b0;
            timer_one_request_flag_o <= 1'b0;
            timer_two_request_flag_o <= 1'b0;
            interrupt_control_o      <= `IRQ_CTRL_RESET;
        end else begin
            skip_o                   <= hit_pd | (|hit_timer);
            timer_one_request_flag_o <= flag_q[0];
            timer_two_request_flag_o <= flag_q[1];
            interrupt_control_o      <= interrupt_control_reg_one_r;
        end
    end
endmodule // flag_skip_instruction_unit

/* File: flag_skip_properties.sv */
// concurrent checks for the flag skip unit
`timescale 1ns/1ps
`include "flag_skip_map.vh"
module flag_skip_properties (
    // clock, reset and core side
    input wire                       clk_i, rst_i, instr_valid_i, powerdown_flag_i,
    input wire                       timer_one_event_i, timer_two_event_i, cyc_i, stb_i,
    input wire [`OPC_WIDTH-1:0]      instr_i,
    // results
    input wire                       skip_o, timer_one_request_flag_o, timer_two_request_flag_o, ack_o,
    input wire [`IRQ_CTRL_WIDTH-1:0] interrupt_control_o
);
    reg  pend_r;
    reg  q_r;
    wire take = instr_valid_i && !skip_o && !pend_r;
    wire w_pd = take && instr_i == `OPC_SKIP_POWERDOWN;
    wire w_t1 = take && instr_i == `OPC_SKIP_TIMER_ONE && q_r && !timer_one_event_i && !cyc_i;
    wire w_t2 = take && instr_i == `OPC_SKIP_TIMER_TWO && q_r && !timer_two_event_i && !cyc_i;
    wire e1 = interrupt_control_o[`TIMER_ONE_EN_BIT];
    wire e2 = interrupt_control_o[`TIMER_TWO_EN_BIT];
    // flag outputs lag a cycle, so only judge after a quiet cycle
    always @(posedge clk_i) begin
        pend_r <= !rst_i && !instr_valid_i && (skip_o || pend_r);
        q_r    <= !(instr_valid_i || cyc_i || timer_one_event_i || timer_two_event_i);
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    pd_skip_a: assert property (w_pd && powerdown_flag_i |=> skip_o)
        else $error("powerdown skip missing");
    pd_hold_a: assert property (w_pd && !powerdown_flag_i |=> !skip_o)
        else $error("powerdown false skip");
    t1_skip_a: assert property (w_t1 && !e1 && timer_one_request_flag_o
        |=> skip_o ##1 !timer_one_request_flag_o) else $error("timer one skip or clear missing");
    t1_nop_a: assert property (w_t1 && e1 && timer_one_request_flag_o
        |=> !skip_o ##1 timer_one_request_flag_o) else $error("timer one not a no-op");
    t1_zero_a: assert property (w_t1 && !timer_one_request_flag_o |=> !skip_o)
        else $error("timer one skipped on zero flag");
    t2_skip_a: assert property (w_t2 && !e2 && timer_two_request_flag_o
        |=> skip_o ##1 !timer_two_request_flag_o) else $error("timer two skip or clear missing");
    t2_nop_a: assert property (w_t2 && e2 && timer_two_request_flag_o
        |=> !skip_o ##1 timer_two_request_flag_o) else $error("timer two not a no-op");
    skip_pulse_a: assert property (skip_o |=> !skip_o)
        else $error("skip longer than one cycle");
    ack_once_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus ack not a single pulse");
endmodule // flag_skip_properties

/* File: test_flag_skip_instruction_unit.sv */
// self-checking bench for the flag skip unit
`timescale 1ns/1ps
`include "flag_skip_map.vh"
module test_flag_skip_instruction_unit;
    reg         clk_i = 0, rst_i = 1, instr_valid_i = 0, pd = 0, cyc_i = 0, we_i = 0;
    reg  [1:0]  ev = 2'h0;
    reg  [9:0]  instr_i = 10'h000;
    reg  [3:0]  adr_i = 4'h0;
    reg  [31:0] dat_i = 32'h0, rd;
    wire        skip_o, ack_o;
    wire [1:0]  fl;
    wire [3:0]  ctl;
    wire [31:0] dat_o;
    integer     err_total = 0, num_checks = 0, cnt = 0;
    // strobe follows cycle, all byte lanes on
    flag_skip_instruction_unit u_flag_skip_instruction_unit (.clk_i(clk_i), .rst_i(rst_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i), .powerdown_flag_i(pd),
        .timer_one_event_i(ev[0]), .timer_two_event_i(ev[1]), .skip_o(skip_o),
        .timer_one_request_flag_o(fl[0]), .timer_two_request_flag_o(fl[1]), .interrupt_control_o(ctl),
        .cyc_i(cyc_i), .stb_i(cyc_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o));
    always #5 clk_i = ~clk_i;
    task chk(input [31:0] seen, exp, input [8*8:1] what);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED %0s expected %0h seen %0h", what, exp, seen);
            end
        end
    endtask
    task wb(input w, input [3:0] a, input [31:0] d);
        begin
            @(posedge clk_i);
            cyc_i <= 1'b1;
            we_i <= w;
            adr_i <= a;
            dat_i <= d;
            @(posedge clk_i);
            while (ack_o !== 1'b1) @(posedge clk_i);
            rd = dat_o;
            cyc_i <= 1'b0;
        end
    endtask
    task ins(input [9:0] w, input exp);
        begin
            @(posedge clk_i);
            instr_valid_i <= 1'b1;
            instr_i <= w;
            @(posedge clk_i);
            instr_valid_i <= 1'b0;
            #1 chk(skip_o, exp, "skip");
        end
    endtask
    task evt(input n);
        begin
            @(posedge clk_i);
            ev[n] <= 1'b1;
            @(posedge clk_i);
            ev[n] <= 1'b0;
            @(posedge clk_i);
            #1;
        end
    endtask
    task tmr(input n);
        reg [9:0] w;
        begin
            w = n ? `OPC_SKIP_TIMER_TWO : `OPC_SKIP_TIMER_ONE;
            wb(1, `ADDR_IRQ_CTRL, 32'h0);
            evt(n);
            ins(w, 1);
            ins(10'h000, 0);
            chk(fl[n], 0, "flag");
            ins(w, 0);
            wb(1, `ADDR_IRQ_CTRL, n ? 32'h8 : 32'h4);
            evt(n);
            chk(ctl, n ? 32'h8 : 32'h4, "ctl");
            ins(w, 0);
            #10 chk(fl[n], 1, "flag");
            // only the other timer's enable set: must still skip
            wb(1, `ADDR_IRQ_CTRL, n ? 32'h4 : 32'h8);
            ins(w, 1);
            ins(10'h000, 0);
        end
    endtask
    task pdn;
        begin
            pd <= 1'b1;
            ins(`OPC_SKIP_POWERDOWN, 1);
            ins(`OPC_SKIP_POWERDOWN, 0);
            wb(0, `ADDR_FLAG_STATUS, 32'h0);
            chk(rd, 32'h1, "status");
            pd <= 1'b0;
            ins(`OPC_SKIP_POWERDOWN, 0);
        end
    endtask
    // software clear and the pending-skip bit of the status word
    task sts(input n);
        reg [31:0] m;
        begin
            m = 32'h1 << (`STAT_TIMER_ONE_BIT + n);
            wb(1, `ADDR_IRQ_CTRL, 32'h0);
            evt(n);
            wb(0, `ADDR_FLAG_STATUS, 32'h0);
            chk(rd, m, "status");
            wb(1, `ADDR_FLAG_STATUS, m);
            wb(0, `ADDR_FLAG_STATUS, 32'h0);
            chk(rd, 32'h0, "status");
            chk(fl[n], 0, "flag");
            evt(n);
            ins(n ? `OPC_SKIP_TIMER_TWO : `OPC_SKIP_TIMER_ONE, 1);
            wb(0, `ADDR_FLAG_STATUS, 32'h0);
            chk(rd, 32'h1 << `STAT_SKIP_BIT, "status");
            ins(10'h000, 0);
            wb(0, `ADDR_FLAG_STATUS, 32'h0);
            chk(rd, 32'h0, "status");
        end
    endtask
    task unm;
        begin
            wb(0, 4'h8, 32'h0);
            chk(rd, 32'h0, "unmapped");
        end
    endtask
    task close_out;
        begin
            $display("checks %0d errors %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    always @(posedge clk_i) begin
        cnt <= cnt + 1;
        if (cnt == 3000) begin
            err_total = err_total + 1;
            close_out;
        end
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        pdn;
        tmr(0);
        tmr(1);
        sts(0);
        sts(1);
        unm;
        close_out;
    end
endmodule // test_flag_skip_instruction_unit
bind flag_skip_instruction_unit flag_skip_properties u_flag_skip_properties (.clk_i(clk_i), .rst_i(rst_i),
    .instr_valid_i(instr_valid_i), .powerdown_flag_i(powerdown_flag_i), .timer_one_event_i(timer_one_event_i),
    .timer_two_event_i(timer_two_event_i), .cyc_i(cyc_i), .stb_i(stb_i), .instr_i(instr_i), .skip_o(skip_o),
    .timer_one_request_flag_o(timer_one_request_flag_o), .timer_two_request_flag_o(timer_two_request_flag_o),
    .ack_o(ack_o), .interrupt_control_o(interrupt_control_o));
